// *** hw/adc_host_if.sv ***
// Conversion control, result hand-out and serial frame generator.
// Function
// - Serial format repurposes three upper data pins
// - Frame: two zeros, then result MSB first
// - Data changes on clock rise, sampled falling
// - Strobe low at start; bit one first fall
// - Serial lines are open-drain, pull low only
// - Serial clock comes from master clock source
// - Format select picks continuous or gated clock
// - Serial-only variant uses clock-run select input
// - First mode starts on start pulse rising
// - First mode status pin is done interrupt
// - Read clears interrupt on first falling edge
// - Power-up leaves interrupt low; dummy read clears
// - Parallel format: one full read, no frame
// - Byte first read picks either byte, clears
// - Second mode starts on select falling edge
// - Second mode status pin shows conversion active
// - Second mode read stalls then returns result
// - Serial behaviour same in both modes
// - Byte layout: low eight, upper six right-justified
// - Conversion lasts 19 or 20 master rises
// - Result is twos-complement code
// Assumes pins are asynchronous to ref_clk and the master clock is far slower.
//
// Our own choices: the APB register port and the register addresses.
`default_nettype none
module adc_host_if
	import adc_host_pkg::*;
(
	input wire logic ref_clk, // System clock
	input wire logic rst, // Asynchronous reset
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic conversion_start_n,
	input wire logic upper_byte_select,
	input wire logic master_clk_in, // External master clock
	input wire logic [CODE_W-1:0] analog_code, // Held code from the converter core
	output logic [CODE_W-1:0] data_out,
	output logic [CODE_W-1:0] data_oe,
	output logic status_n, // Done interrupt or active flag
	output logic serial_clock_out,
	output logic serial_clock_oe,
	output logic serial_data_out,
	output logic serial_data_oe,
	output logic serial_frame_strobe_n,
	output logic serial_frame_strobe_oe
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pins_t s1; // First synchroniser stage
		pins_t s2; // Second synchroniser stage
		pins_t prev; // Previous synchronised value
		logic [CODE_W-1:0] c1;
		logic [CODE_W-1:0] c2;
		cfg_t cfg;
		logic [15:0] div_cnt; // Internal oscillator divider
		logic osc;
		logic mclk_prev;
		state_t st;
		logic [4:0] edge_cnt; // Counted master rises
		logic [4:0] rises; // All rises seen, for checking
		logic [2:0] align_cnt;
		logic skipped; // First rise fell in the late window
		logic [CODE_W-1:0] held; // Sampled at start of hold
		logic [CODE_W-1:0] result;
		logic [FRAME_BITS-1:0] shreg;
		logic [4:0] bit_cnt;
		logic frame_on;
		logic fell_seen; // Frame's first falling edge has passed
		logic pin_n;
		logic collide; // Read seen during a first-mode conversion
		logic [CODE_W-1:0] dout;
		logic [CODE_W-1:0] doe;
		logic sclk_oe;
		logic serial_data_out_oe;
		logic serial_frame_strobe_n_oe;
		logic [31:0] rdata;
		logic rdy;
		logic err;
	} regs_t;

	regs_t r; // Registered state
	regs_t next_r; // Next state

	// Decode an APB address into a register index, 3'h7 when unmapped
	function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_CTRL: reg_index = 3'h0;
			ADDR_STAT: reg_index = 3'h1;
			ADDR_RES: reg_index = 3'h2;
			ADDR_DIV: reg_index = 3'h3;
			default: reg_index = 3'h7;
		endcase
	endfunction : reg_index

	// ----------------------------------------------------------------
	// Derived terms
	// ----------------------------------------------------------------
	logic mclk_lvl; // Selected master clock level
	logic mclk_rise;
	logic mclk_fall;
	logic rd_act; // Chip select and read strobe both low
	logic rd_start; // First cycle of a read
	logic ser_en; // Serial pins in use
	logic cont; // Free-running serial clock
	logic start1;
	logic start2;
	logic conv_end;
	logic apb_acc;

	// Source, edge and mode terms
	always_comb
	begin
		mclk_lvl = r.cfg.ext_clk ? r.s2.mclk : r.osc;
		mclk_rise = mclk_lvl && !r.mclk_prev;
		mclk_fall = !mclk_lvl && r.mclk_prev;
		rd_act = !r.s2.cs_n && !r.s2.rd_n;
		rd_start = rd_act && !(!r.prev.cs_n && !r.prev.rd_n);
		ser_en = r.cfg.ser_only || (r.cfg.fmt != FMT_PAR);
		cont = r.cfg.ser_only ? r.cfg.clk_run : (r.cfg.fmt == FMT_SER_CONT);
		// Restarts are ignored while busy, so a stray pulse cannot corrupt the run
		start1 = !r.cfg.mode2 && (r.st == ST_IDLE) && r.s2.conversion_start_n_n && !r.prev.conversion_start_n_n;
		start2 = r.cfg.mode2 && (r.st == ST_IDLE) && !r.s2.conversion_start_n_n && !r.s2.ubs
			&& !r.s2.cs_n && r.prev.cs_n;
		conv_end = (r.st == ST_CONV) && mclk_rise && !(r.edge_cnt == 5'h00 && !r.skipped
			&& r.align_cnt < ALIGN_CYC) && (r.edge_cnt == CONV_EDGES - 5'h01);
		apb_acc = psel && penable && r.rdy;
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		// Two-stage synchronisers; stage one feeds stage two only
		next_r.s1 = '{cs_n: chip_select_n, rd_n: read_strobe_n, conversion_start_n_n: conversion_start_n,
			ubs: upper_byte_select, mclk: master_clk_in};
		next_r.s2 = r.s1;
		next_r.prev = r.s2;
		next_r.c1 = analog_code;
		next_r.c2 = r.c1;
		next_r.mclk_prev = mclk_lvl;

		// Internal oscillator stands in when no external clock is fitted
		if (r.div_cnt >= r.cfg.div_half)
		begin
			next_r.div_cnt = 16'h0001;
			next_r.osc = !r.osc;
		end
		else
		begin
			next_r.div_cnt = r.div_cnt + 16'h0001;
		end

		// Sequencer
		case (r.st)
			ST_IDLE:
			begin
				if (start1 || start2)
				begin
					next_r.st = ST_CONV;
					next_r.edge_cnt = 5'h00;
					next_r.rises = 5'h00;
					next_r.align_cnt = 3'h0;
					next_r.skipped = 1'b0;
					next_r.held = r.c2;
					// Frame is built identically for both start modes
					next_r.frame_on = ser_en;
					next_r.fell_seen = mclk_fall;
					next_r.shreg = {2'b00, r.c2};
					next_r.bit_cnt = 5'h00;
					if (r.cfg.mode2)
					begin
						next_r.pin_n = 1'b0;
					end
				end
			end
			ST_CONV:
			begin
				if (r.align_cnt < ALIGN_CYC)
				begin
					next_r.align_cnt = r.align_cnt + 3'h1;
				end
				if (mclk_rise)
				begin
					next_r.rises = r.rises + 5'h01;
					// A rise just after the start is not counted, giving 20 in all
					if (r.edge_cnt == 5'h00 && !r.skipped && r.align_cnt < ALIGN_CYC)
					begin
						next_r.skipped = 1'b1;
					end
					else
					begin
						next_r.edge_cnt = r.edge_cnt + 5'h01;
					end
				end
				if (conv_end)
				begin
					next_r.st = ST_IDLE;
					next_r.result = r.held;
					next_r.pin_n = r.cfg.mode2;
				end
			end
			default:
			begin
				next_r.st = ST_IDLE;
			end
		endcase

		// Serial frame: shift on rises once the first fall has presented bit one
		if (r.frame_on)
		begin
			if (mclk_fall)
			begin
				next_r.fell_seen = 1'b1;
			end
			if (mclk_rise && r.fell_seen)
			begin
				if (r.bit_cnt == LAST_BIT)
				begin
					next_r.frame_on = 1'b0;
				end
				else
				begin
					next_r.shreg = {r.shreg[FRAME_BITS-2:0], 1'b0};
					next_r.bit_cnt = r.bit_cnt + 5'h01;
				end
			end
		end

		// First-mode interrupt clears on a read; a simultaneous end keeps it low
		if (!r.cfg.mode2 && rd_start && !conv_end)
		begin
			next_r.pin_n = 1'b1;
		end

		// Parallel data pins, driven only while the read is asserted
		next_r.doe = '0;
		next_r.dout = r.dout;
		if (rd_act && !r.cfg.ser_only)
		begin
			if (r.cfg.fmt == FMT_PAR)
			begin
				next_r.doe = '1;
				next_r.dout = r.result;
			end
			else
			begin
				next_r.doe = {{(CODE_W-8){1'b0}}, 8'hff};
				next_r.dout = r.s2.ubs ? {6'h00, 2'b00, r.result[CODE_W-1:8]}
					: {6'h00, r.result[7:0]};
			end
		end

		// Open-drain serial lines: enable means pull low
		next_r.serial_frame_strobe_n_oe = next_r.frame_on && ser_en;
		next_r.serial_data_out_oe = next_r.frame_on && ser_en && !next_r.shreg[FRAME_BITS-1];
		// Gated clock waits for the frame's first fall, else the receiver sees a spare bit
		next_r.sclk_oe = ser_en && (cont || (next_r.frame_on && next_r.fell_seen))
			&& !mclk_lvl;

		// Read during a first-mode conversion is flagged, setting wins over clearing
		if (r.st == ST_CONV && !r.cfg.mode2 && rd_act)
		begin
			next_r.collide = 1'b1;
		end
		else if (apb_acc && pwrite && reg_index(paddr) == 3'h1 && pwdata[STAT_COLL])
		begin
			next_r.collide = 1'b0;
		end

		// APB slave: one wait state, then registered answer
		next_r.rdy = psel && penable && !r.rdy;
		next_r.err = psel && penable && !r.rdy && (reg_index(paddr) == 3'h7);
		next_r.rdata = 32'h00000000;
		if (psel && penable && !r.rdy && !pwrite)
		begin
			case (reg_index(paddr))
				3'h0: next_r.rdata = {26'h0000000, r.cfg.ext_clk, r.cfg.clk_run, r.cfg.ser_only,
					r.cfg.fmt, r.cfg.mode2};
				3'h1: next_r.rdata = {28'h0000000, r.collide, r.frame_on, r.pin_n,
					r.st == ST_CONV};
				3'h2: next_r.rdata = {{(32-CODE_W){1'b0}}, r.result};
				3'h3: next_r.rdata = {16'h0000, r.cfg.div_half};
				default: next_r.rdata = 32'h00000000;
			endcase
		end
		if (apb_acc && pwrite)
		begin
			case (reg_index(paddr))
				3'h0:
				begin
					next_r.cfg.mode2 = pwdata[CTRL_MODE];
					next_r.cfg.fmt = fmt_t'(pwdata[CTRL_FMT+1:CTRL_FMT]);
					next_r.cfg.ser_only = pwdata[CTRL_SONLY];
					next_r.cfg.clk_run = pwdata[CTRL_CRUN];
					next_r.cfg.ext_clk = pwdata[CTRL_EXTCLK];
				end
				3'h3: next_r.cfg.div_half = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
				default: next_r.cfg = r.cfg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.s1 <= '1;
			r.s2 <= '1;
			r.prev <= '1;
			r.cfg.div_half <= DIV_RST;
			r.pin_n <= 1'b0;
		end
		else
		begin
			r <= next_r;
		end
	end

	// Outputs straight from flops; open-drain pins only ever pull low
	assign prdata = r.rdata;
	assign pready = r.rdy;
	assign pslverr = r.err;
	assign data_out = r.dout;
	assign data_oe = r.doe;
	assign status_n = r.pin_n;
	assign serial_clock_out = r.sclk_oe && 1'b0;
	assign serial_data_out = r.serial_data_out_oe && 1'b0;
	assign serial_frame_strobe_n = r.serial_frame_strobe_n_oe && 1'b0;
	assign serial_clock_oe = r.sclk_oe;
	assign serial_data_oe = r.serial_data_out_oe;
	assign serial_frame_strobe_oe = r.serial_frame_strobe_n_oe;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_frame_content;
		$rose(r.frame_on) |-> r.shreg[FRAME_BITS-1:FRAME_BITS-2] == 2'b00 && r.shreg[CODE_W-1:0] == r.held;
	endproperty
	a_frame_content: assert property (p_frame_content) else $error("frame lacks zeros or code");

	property p_strobe_at_start;
		(r.st == ST_IDLE && (start1 || start2) && ser_en) |=> r.frame_on && r.serial_frame_strobe_n_oe;
	endproperty
	a_strobe_at_start: assert property (p_strobe_at_start) else $error("strobe not low at start");

	property p_shift_on_rise;
		(r.frame_on && $past(r.frame_on) && $changed(r.shreg)) |-> $past(mclk_rise);
	endproperty
	a_shift_on_rise: assert property (p_shift_on_rise) else $error("data moved off a rise");

	property p_sclk_low_only;
		r.sclk_oe |-> !$past(mclk_lvl);
	endproperty
	a_sclk_low_only: assert property (p_sclk_low_only) else $error("clock pulled while high");

	property p_parallel_quiet;
		(r.cfg.fmt == FMT_PAR && !r.cfg.ser_only && $past(r.cfg.fmt) == FMT_PAR && !$past(r.cfg.ser_only)
			&& !$past(r.frame_on)) |-> !r.frame_on && !r.serial_frame_strobe_n_oe;
	endproperty
	a_parallel_quiet: assert property (p_parallel_quiet) else $error("frame in parallel format");

	property p_done_irq;
		(conv_end && !r.cfg.mode2) |=> !r.pin_n [*2];
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("done not signalled");

	property p_irq_cleared;
		(!r.cfg.mode2 && rd_start && !conv_end && r.st == ST_IDLE) |=> r.pin_n;
	endproperty
	a_irq_cleared: assert property (p_irq_cleared) else $error("read did not clear done");

	property p_busy_level;
		(r.cfg.mode2 && $past(r.cfg.mode2) && r.st == ST_CONV && $past(r.st) == ST_CONV) |-> !r.pin_n;
	endproperty
	a_busy_level: assert property (p_busy_level) else $error("active flag high in conversion");

	property p_conv_edges;
		conv_end |-> (r.rises + 5'h01 == CONV_EDGES) || (r.rises + 5'h01 == CONV_EDGES_LATE);
	endproperty
	a_conv_edges: assert property (p_conv_edges) else $error("conversion length off");

	property p_upper_byte;
		(r.doe[7] && !r.doe[8] && $past(r.s2.ubs)) |-> r.dout[7:6] == 2'b00;
	endproperty
	a_upper_byte: assert property (p_upper_byte) else $error("upper byte not justified");

	property p_bus_release;
		!$past(rd_act) |-> r.doe == '0;
	endproperty
	a_bus_release: assert property (p_bus_release) else $error("data driven outside read");

	property p_gated_release;
		(!r.frame_on && !$past(r.frame_on) && !cont && !$past(cont)) |-> !r.sclk_oe && !r.serial_data_out_oe;
	endproperty
	a_gated_release: assert property (p_gated_release) else $error("serial lines not released");

	c_frame_done: cover property ($fell(r.frame_on) && r.bit_cnt == LAST_BIT);
	c_mode2_conv: cover property (r.cfg.mode2 && conv_end);
	c_late_start: cover property (conv_end && r.skipped);
	c_upper_read: cover property (r.doe[0] && $past(r.s2.ubs) && r.cfg.fmt != FMT_PAR);
endmodule : adc_host_if
`default_nettype wire

// *** hw/adc_host_pkg.sv ***
// Shared constants, enums and carrier structs for the converter host interface.
// Assumes a single 200 MHz ref_clk domain; all pins arrive asynchronously.
`default_nettype none
package adc_host_pkg;
	// ----------------------------------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_RES = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_DIV = 12'h00c;
	// Control field positions
	localparam int CTRL_MODE = 0;
	localparam int CTRL_FMT = 1;
	localparam int CTRL_SONLY = 3;
	localparam int CTRL_CRUN = 4;
	localparam int CTRL_EXTCLK = 5;
	// Status field positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_PIN = 1;
	localparam int STAT_FRAME = 2;
	localparam int STAT_COLL = 3;
	// ----------------------------------------------------------------
	// Converter and frame figures
	// ----------------------------------------------------------------
	localparam int CODE_W = 14;
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] CONV_EDGES = 5'h13;
	localparam logic [4:0] CONV_EDGES_LATE = 5'h14;
	localparam logic [4:0] LAST_BIT = 5'h0f;
	localparam int CLK_MHZ = 200;
	localparam int ALIGN_NS = 30;
	localparam logic [2:0] ALIGN_CYC = 3'((ALIGN_NS * CLK_MHZ) / 1000);
	localparam logic [15:0] DIV_RST = 16'h0032;
	// Output format select levels
	typedef enum logic [1:0] {
		FMT_PAR = 2'b00,
		FMT_SER_GATED = 2'b01,
		FMT_SER_CONT = 2'b10
	} fmt_t;
	// Converter sequencer
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_CONV = 1'b1
	} state_t;
	// Host-side pins as one group
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic conversion_start_n_n;
		logic ubs;
		logic mclk;
	} pins_t;
	// Software configuration
	typedef struct packed {
		logic mode2;
		fmt_t fmt;
		logic ser_only;
		logic clk_run;
		logic ext_clk;
		logic [15:0] div_half;
	} cfg_t;
endpackage : adc_host_pkg
`default_nettype wire

// *** bench/adc_host_partner.sv ***
// Host partner: drives the host pins, pulls the open-drain lines up, gathers serial frames.
// Assumes its tasks are entered just after a ref_clk rising edge.
`default_nettype none
module host_model
	import adc_host_pkg::*;
(
	input wire logic ref_clk,
	input wire logic master_clk_in,
	input wire logic [CODE_W-1:0] data_out,
	input wire logic [CODE_W-1:0] data_oe,
	input wire logic status_n,
	input wire logic serial_clock_out,
	input wire logic serial_clock_oe,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic serial_frame_strobe_n,
	input wire logic serial_frame_strobe_oe,
	output logic chip_select_n,
	output logic read_strobe_n,
	output logic conversion_start_n,
	output logic upper_byte_select,
	output logic [15:0] frame_word,
	output int frame_bits,
	output int frame_cnt,
	output int idle_falls,
	output int hang
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------
	// Line levels
	// ------------------------
	logic sclk_l; // Resolved serial clock
	logic sdat_l; // Resolved serial data
	logic strb_l; // Resolved frame strobe
	logic sclk_q = 1'b1; // Clock one cycle back
	logic strb_q = 1'b1; // Strobe one cycle back
	logic [15:0] shreg = '0; // Bits of the open frame
	int bits = 0;
	logic [CODE_W-1:0] bus; // Parallel bus as the host sees it
	// Pull-ups give the high level; the design may only pull low
	assign sclk_l = serial_clock_oe ? serial_clock_out : 1'b1;
	assign sdat_l = serial_data_oe ? serial_data_out : 1'b1;
	assign strb_l = serial_frame_strobe_oe ? serial_frame_strobe_n : 1'b1;
	// A released pin reads inverted, so stale data can never pass
	assign bus = data_out ^ ~data_oe;
	initial
	begin
		chip_select_n = 1'b1;
		read_strobe_n = 1'b1;
		conversion_start_n = 1'b1;
		upper_byte_select = 1'b0;
		frame_word = '0;
		frame_bits = 0;
		frame_cnt = 0;
		idle_falls = 0;
		hang = 0;
	end
	// Receiver: takes data on falling clock while the strobe is low
	always @(posedge ref_clk)
	begin
		sclk_q <= sclk_l;
		strb_q <= strb_l;
		if (sclk_q && !sclk_l && !strb_l)
		begin
			shreg <= {shreg[14:0], sdat_l};
			bits <= bits + 1;
		end
		if (sclk_q && !sclk_l && strb_l)
			idle_falls <= idle_falls + 1;
		// Strobe release closes the frame
		if (!strb_q && strb_l)
		begin
			frame_word <= shreg;
			frame_bits <= bits;
			frame_cnt <= frame_cnt + 1;
			bits <= 0;
		end
	end
	// ------------------------
	// Host pin tasks
	// ------------------------
	// Start pin held low for the second start mode, high otherwise
	task automatic start_level(input logic lvl);
		@(posedge ref_clk);
		conversion_start_n <= lvl;
	endtask : start_level
	// One low start pulse of four ref_clk cycles, sent without checking whether the converter is idle
	task automatic pulse_start();
		@(posedge ref_clk);
		conversion_start_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		conversion_start_n <= 1'b1;
	endtask : pulse_start
	// Waits for the done flag, counting master clock rises meanwhile
	task automatic wait_done(output int rises);
		int n;
		logic mq;
		mq = master_clk_in;
		rises = 0;
		for (n = 0; n < 2000 && status_n !== 1'b0; n++)
		begin
			@(posedge ref_clk);
			if (master_clk_in && !mq)
				rises++;
			mq = master_clk_in;
		end
		if (n == 2000)
			hang++;
	endtask : wait_done
	// Read; slow reads are made with start held low, span a second-mode conversion and stall on status
	task automatic read(input logic ub, input logic slow, output logic [CODE_W-1:0] d,
		output logic [CODE_W-1:0] oe);
		int n;
		int w;
		@(posedge ref_clk);
		upper_byte_select <= ub;
		chip_select_n <= 1'b0;
		read_strobe_n <= 1'b0;
		n = 0;
		w = 0;
		if (slow)
		begin
			for (n = 0; n < 20 && status_n !== 1'b0; n++)
				@(posedge ref_clk);
			for (w = 0; w < 2000 && status_n !== 1'b1; w++)
				@(posedge ref_clk);
		end
		if (n == 20 || w == 2000)
			hang++;
		repeat (6) @(posedge ref_clk);
		d = bus;
		oe = data_oe;
		chip_select_n <= 1'b1;
		read_strobe_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask : read
endmodule : host_model
`default_nettype wire

// *** bench/sampling_adc_host_interface_tb.sv ***
// Self-checking bench for the converter host interface.
// Assumes the partner model drives the host pins; APB is driven from here.
`default_nettype none
module sampling_adc_host_interface_tb
	import adc_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------
	// Signals
	// ------------------------
	logic ref_clk = 1'b0;
	logic master_clk_in = 1'b0; // 64 ns external master clock
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [CODE_W-1:0] analog_code = '0;
	logic [31:0] prdata;
	logic pready, pslverr, status_n;
	logic chip_select_n, read_strobe_n, conversion_start_n, upper_byte_select;
	logic [CODE_W-1:0] data_out, data_oe;
	logic serial_clock_out, serial_clock_oe, serial_data_out, serial_data_oe;
	logic serial_frame_strobe_n, serial_frame_strobe_oe;
	logic [15:0] frame_word;
	int frame_bits, frame_cnt, idle_falls, hang;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] lfsr = 32'ha0f5; // Fixed seed
	logic [CODE_W-1:0] exp_q[$]; // Sampled codes awaiting hand-out
	// Configurations {ext_clk, clk_run, serial_only, fmt, mode2}
	logic [5:0] cfgs[8] = '{6'h20, 6'h22, 6'h24, 6'h21, 6'h23, 6'h28, 6'h38, 6'h02};
	always #2.5 ref_clk = ~ref_clk;
	// Free-running, phase unrelated to ref_clk
	always #32 master_clk_in = ~master_clk_in;
	adc_host_if adc_host_if_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .chip_select_n, .read_strobe_n, .conversion_start_n, .upper_byte_select,
		.master_clk_in, .analog_code, .data_out, .data_oe, .status_n, .serial_clock_out,
		.serial_clock_oe, .serial_data_out, .serial_data_oe, .serial_frame_strobe_n,
		.serial_frame_strobe_oe);
	host_model host_model_i (.ref_clk, .master_clk_in, .data_out, .data_oe, .status_n,
		.serial_clock_out, .serial_clock_oe, .serial_data_out, .serial_data_oe,
		.serial_frame_strobe_n, .serial_frame_strobe_oe, .chip_select_n, .read_strobe_n,
		.conversion_start_n, .upper_byte_select, .frame_word, .frame_bits, .frame_cnt,
		.idle_falls, .hang);
	// ------------------------
	// Tasks
	// ------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	// Byte format puts the upper six bits right-justified
	function automatic logic [CODE_W-1:0] exp_val(input logic byt, input logic ub, input logic [CODE_W-1:0] v);
		if (!byt)
			return v;
		return ub ? {8'h00, v[13:8]} : {6'h00, v[7:0]};
	endfunction : exp_val
	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge ref_clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
		if (n == 40)
		begin
			fail_count++;
			test_done();
		end
	endtask : apb
	// One conversion in configuration c, then the read and the frame are judged
	task automatic run_case(input logic [5:0] c);
		logic [CODE_W-1:0] d, o, e, mask;
		logic [31:0] rd;
		logic err, ser, cont, byt, ub;
		int n, f0, i0;
		ser = c[3] || c[2:1] != 2'b00;
		cont = c[3] ? c[4] : c[2:1] == 2'b10;
		byt = !c[3] && c[2:1] != 2'b00;
		mask = byt ? 14'h00ff : 14'h3fff;
		ub = !c[0] && c[2];
		lfsr = lfsr_next(lfsr);
		analog_code <= lfsr[CODE_W-1:0];
		exp_q.push_back(lfsr[CODE_W-1:0]);
		apb(1'b1, ADDR_CTRL, {26'h0, c}, rd, err);
		apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
		check("control", rd, {26'h0, c});
		f0 = frame_cnt;
		check("bus idle", 32'(data_oe), 32'h0);
		if (c[0])
		begin
			host_model_i.start_level(1'b0);
			host_model_i.read(1'b0, 1'b1, d, o);
			host_model_i.start_level(1'b1);
		end
		else
		begin
			host_model_i.pulse_start();
			host_model_i.wait_done(n);
			if (c[5])
				check("master rises", 32'(n >= 19 && n <= 21), 32'h1);
			host_model_i.read(ub, 1'b0, d, o);
		end
		check("status after read", 32'(status_n), 32'h1);
		e = exp_q.pop_front();
		apb(1'b0, ADDR_RES, 32'h0, rd, err);
		check("result register", rd, 32'(e));
		if (!c[3])
		begin
			check("read data", 32'(d & mask), 32'(exp_val(byt, ub, e)));
			check("pins driven", 32'(o), 32'(mask));
		end
		if (byt)
		begin
			host_model_i.read(!ub, 1'b0, d, o);
			check("second byte", 32'(d & mask), 32'(exp_val(byt, !ub, e)));
		end
		for (n = 0; ser && n < 2000 && frame_cnt == f0; n++)
			@(posedge ref_clk);
		check("frames", 32'(frame_cnt - f0), 32'(ser));
		if (ser)
		begin
			check("frame bits", 32'(frame_bits), 32'h10);
			check("frame word", 32'(frame_word), 32'({2'b00, e}));
		end
		i0 = idle_falls;
		repeat (64) @(posedge ref_clk);
		check("clock between frames", 32'(idle_falls != i0), 32'(cont));
		if (!cont)
			check("lines released", 32'({serial_clock_oe, serial_data_oe, serial_frame_strobe_oe}), 32'h0);
		apb(1'b0, ADDR_STAT, 32'h0, rd, err);
		check("status word", rd, 32'h2);
		$display("case %h done", c);
	endtask : run_case
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	// Cuts a hang short: a stuck partner wait or an overlong run
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (hang != 0 || cycles > 100000)
		begin
			fail_count++;
			test_done();
		end
	end
	// Main sequence: power-up state, registers, then every configuration
	initial
	begin
		logic [31:0] rd;
		logic err;
		logic [CODE_W-1:0] d, o;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check("status at power-up", 32'(status_n), 32'h0);
		host_model_i.read(1'b0, 1'b0, d, o);
		check("status after dummy read", 32'(status_n), 32'h1);
		apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
		check("control reset", rd, 32'h0);
		apb(1'b0, ADDR_DIV, 32'h0, rd, err);
		check("divider reset", rd, {16'h0, DIV_RST});
		apb(1'b1, ADDR_DIV, 32'h2, rd, err);
		apb(1'b0, ADDR_DIV, 32'h0, rd, err);
		check("divider", rd, 32'h2);
		apb(1'b0, 12'h010, 32'h0, rd, err);
		check("unmapped error", 32'(err), 32'h1);
		check("unmapped data", rd, 32'h0);
		foreach (cfgs[i])
			run_case(cfgs[i]);
		test_done();
	end
endmodule : sampling_adc_host_interface_tb
`default_nettype wire
